/* logic/channel_memory_request_queues.sv */
// Memory request queues and sequencer for eight channels of a channel control.
// Assumes one clock; event inputs are synchronous and carry the channel of the
// RAM cycle that raised them; memory answers each word with a strobe.
`timescale 1ns/1ps
module channel_memory_request_queues #(
   parameter int CHANNELS = mrq_pkg::CHANNELS
) (
   // Clock, reset and enable
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   // Channel events, each steered by event_channel
   input wire logic [mrq_pkg::CHAN_W-1:0] event_channel,
   input wire logic channel_start,
   input wire logic start_controller_to_memory,
   input wire logic word_count_zero_normal,
   input wire logic jump_command_loaded,
   input wire logic action_group_request,
   input wire logic [mrq_pkg::LEN_W-1:0] action_group_words,
   input wire logic store_request,
   // Competing requests on the channel side
   input wire logic channel_bus_word_request,
   input wire logic control_request_pending,
   // Memory buffer side
   input wire logic memory_word_enter,
   input wire logic memory_word_leave,
   input wire logic memory_error,
   output logic hold_memory,
   output logic memory_request_active,
   output mrq_pkg::request_kind_t memory_request_kind,
   output logic [mrq_pkg::LEN_W-1:0] memory_request_words,
   // Control RAM cycle and buffer addressing
   output mrq_pkg::ram_cycle_t ram_cycle,
   output logic [mrq_pkg::CHAN_W-1:0] ram_channel,
   output logic use_command_word_buffer,
   output logic [mrq_pkg::PTR_W-1:0] buffer_word_pointer,
   output logic [mrq_pkg::LEN_W-1:0] words_in_memory_buffer,
   // Channel status
   output logic [CHANNELS-1:0] channel_error,
   output logic [CHANNELS-1:0] controller_to_memory,
   output logic [mrq_pkg::NUM_QUEUES*CHANNELS-1:0] queue_pending
);
   // ***************************************************************
   // Types and state
   // ***************************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_MOVE,
      ST_UPDATE,
      ST_ERROR
   } seq_state_t;

   typedef struct packed {
      seq_state_t seq;
      logic [1:0] queue;
      logic [mrq_pkg::CHAN_W-1:0] channel;
      mrq_pkg::request_kind_t kind;
      logic [mrq_pkg::LEN_W-1:0] words;
      logic failed;
      logic [CHANNELS-1:0] direction;
      logic [CHANNELS-1:0] error_bits;
      logic [CHANNELS-1:0][mrq_pkg::LEN_W-1:0] group_len;
      logic [CHANNELS-1:0][mrq_pkg::PTR_W-1:0] mem_ptr;
   } top_state_t;

   top_state_t state_reg;
   top_state_t state_next;
   logic [1:0] rst_sync_reg;
   logic rst_sync_b;
   logic [mrq_pkg::NUM_QUEUES-1:0] q_set;
   logic [mrq_pkg::NUM_QUEUES-1:0] q_clear;
   logic [mrq_pkg::NUM_QUEUES-1:0] q_any;
   logic [mrq_pkg::NUM_QUEUES-1:0][mrq_pkg::CHAN_W-1:0] q_winner;
   logic [mrq_pkg::NUM_QUEUES-1:0][CHANNELS-1:0] q_bits;
   logic any_request;
   logic grant_ok;
   logic [1:0] win_queue;
   logic [mrq_pkg::CHAN_W-1:0] win_channel;
   logic [mrq_pkg::LEN_W-1:0] clamped_len;

   mover_if mover_link();

   // ***************************************************************
   // Reset release
   // ***************************************************************
   // Two flops release the reset cleanly; assertion stays asynchronous.
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_sync_b = rst_sync_reg[1];

   // ***************************************************************
   // Request queues
   // ***************************************************************
   // fetch queue causes
   always_comb
   begin
      q_set[mrq_pkg::Q_FETCH] = channel_start || word_count_zero_normal
         || jump_command_loaded;
      q_set[mrq_pkg::Q_GROUP] = action_group_request;
      q_set[mrq_pkg::Q_STORE] = store_request;
   end

   always_comb
   begin
      for (int q = 0; q < mrq_pkg::NUM_QUEUES; q++)
         q_clear[q] = (state_reg.seq == ST_SETUP) && (state_reg.queue == 2'(q));
   end

   // One queue per request type, each with its own encoder.
   genvar gq;
   generate
      for (gq = 0; gq < mrq_pkg::NUM_QUEUES; gq++)
      begin : g_queue
         request_queue #(
            .CHANNELS(CHANNELS),
            .CHAN_W(mrq_pkg::CHAN_W)
         ) u_queue (
            .clock(clock),
            .rst_b(rst_sync_b),
            .clk_en(clk_en),
            .set_valid(q_set[gq]),
            .set_channel(event_channel),
            .clear_valid(q_clear[gq]),
            .clear_channel(state_reg.channel),
            .pending(q_bits[gq]),
            .any_pending(q_any[gq]),
            .winner(q_winner[gq])
         );
         assign queue_pending[gq*CHANNELS +: CHANNELS] = q_bits[gq];
      end
   endgenerate

   // ***************************************************************
   // Priority between queues
   // ***************************************************************
   // fixed queue order
   always_comb
   begin
      if (q_any[mrq_pkg::Q_FETCH])
         win_queue = 2'(mrq_pkg::Q_FETCH);
      else if (q_any[mrq_pkg::Q_GROUP])
         win_queue = 2'(mrq_pkg::Q_GROUP);
      else
         win_queue = 2'(mrq_pkg::Q_STORE);
   end
   assign win_channel = q_winner[win_queue];
   assign any_request = |q_any;
   assign grant_ok = any_request && !channel_bus_word_request && !control_request_pending;

   assign clamped_len = (state_reg.group_len[win_channel] > mrq_pkg::MAX_GROUP_WORDS)
      ? mrq_pkg::MAX_GROUP_WORDS : state_reg.group_len[win_channel];

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   // Grants one request, runs setup, transfer, update and error cycles.
   always_comb
   begin
      state_next = state_reg;
      if (channel_start)
      begin
         state_next.direction[event_channel] = start_controller_to_memory;
         state_next.error_bits[event_channel] = 1'b0;
         state_next.mem_ptr[event_channel] = mrq_pkg::PTR_RESET;
      end
      if (action_group_request)
         state_next.group_len[event_channel] = action_group_words;
      case (state_reg.seq)
         ST_IDLE:
         begin
            if (grant_ok)
            begin
               state_next.seq = ST_SETUP;
               state_next.queue = win_queue;
               state_next.channel = win_channel;
               state_next.failed = 1'b0;
               if (win_queue == 2'(mrq_pkg::Q_FETCH))
               begin
                  state_next.kind = mrq_pkg::KIND_FETCH_COMMAND;
                  state_next.words = mrq_pkg::FETCH_WORDS;
               end
               else if (win_queue == 2'(mrq_pkg::Q_GROUP))
               begin
                  state_next.kind = state_reg.direction[win_channel]
                     ? mrq_pkg::KIND_WRITE_GROUP : mrq_pkg::KIND_READ_GROUP;
                  state_next.words = (clamped_len == 3'h0) ? 3'h1 : clamped_len;
               end
               else
               begin
                  state_next.kind = mrq_pkg::KIND_STORE_COMMAND;
                  state_next.words = mrq_pkg::STORE_WORDS;
               end
            end
         end
         ST_SETUP:
            state_next.seq = ST_MOVE;
         ST_MOVE:
         begin
            if (memory_error)
               state_next.failed = 1'b1;
            if (mover_link.done)
               state_next.seq = ST_UPDATE;
         end
         ST_UPDATE:
         begin
            if (state_reg.kind == mrq_pkg::KIND_READ_GROUP
                  || state_reg.kind == mrq_pkg::KIND_WRITE_GROUP)
               state_next.mem_ptr[state_reg.channel] =
                  state_reg.mem_ptr[state_reg.channel] + state_reg.words;
            state_next.seq = state_reg.failed ? ST_ERROR : ST_IDLE;
         end
         ST_ERROR:
         begin
            state_next.error_bits[state_reg.channel] = 1'b1;
            state_next.seq = ST_IDLE;
         end
         default:
            state_next.seq = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         state_reg <= '{seq: ST_IDLE, kind: mrq_pkg::KIND_FETCH_COMMAND, default: '0};
      else if (clk_en)
         state_reg <= state_next;
   end

   // ***************************************************************
   // Word counting
   // ***************************************************************
   // record words to move
   assign mover_link.start = (state_reg.seq == ST_SETUP);
   assign mover_link.total = state_reg.words;
   assign mover_link.to_controller = (state_reg.kind == mrq_pkg::KIND_FETCH_COMMAND)
      || (state_reg.kind == mrq_pkg::KIND_READ_GROUP);
   assign mover_link.word_enter = (state_reg.seq == ST_MOVE) && memory_word_enter;
   assign mover_link.word_leave = (state_reg.seq == ST_MOVE) && memory_word_leave;

   word_mover u_mover (
      .clock(clock),
      .rst_b(rst_sync_b),
      .clk_en(clk_en),
      .link(mover_link.mover)
   );

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // hold memory
   assign hold_memory = any_request || (state_reg.seq != ST_IDLE);
   assign memory_request_active = (state_reg.seq == ST_MOVE);
   assign memory_request_kind = state_reg.kind;
   assign memory_request_words = state_reg.words;
   assign ram_channel = (state_reg.seq == ST_IDLE) ? event_channel : state_reg.channel;
   assign use_command_word_buffer = (state_reg.kind == mrq_pkg::KIND_FETCH_COMMAND)
      || (state_reg.kind == mrq_pkg::KIND_STORE_COMMAND);
   assign buffer_word_pointer = use_command_word_buffer ? mover_link.offset
      : state_reg.mem_ptr[state_reg.channel] + mover_link.offset;
   assign words_in_memory_buffer = mover_link.in_buffer;
   assign channel_error = state_reg.error_bits;
   assign controller_to_memory = state_reg.direction;

   // Announce the control RAM cycle that the sequencer is running.
   always_comb
   begin
      case (state_reg.seq)
         ST_SETUP: ram_cycle = mrq_pkg::RAM_SETUP;
         ST_UPDATE: ram_cycle = mrq_pkg::RAM_UPDATE;
         ST_ERROR: ram_cycle = mrq_pkg::RAM_ERROR;
         default: ram_cycle = mrq_pkg::RAM_NONE;
      endcase
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_b);

   sequence s_grant;
      clk_en && state_reg.seq == ST_IDLE && grant_ok;
   endsequence
   sequence s_setup_then_move;
      state_reg.seq == ST_SETUP ##1 state_reg.seq == ST_MOVE;
   endsequence

   AST_GRANT_STARTS_SETUP: assert property (
      s_grant |=> s_setup_then_move)
      else $error("Grant did not run a setup cycle then transfer.");
   AST_NO_GRANT_UNDER_BUS: assert property (
      clk_en && state_reg.seq == ST_IDLE
      && (channel_bus_word_request || control_request_pending) |=> state_reg.seq == ST_IDLE)
      else $error("Memory request granted while bus traffic pending.");
   AST_FETCH_FIRST: assert property (
      s_grant and q_any[mrq_pkg::Q_FETCH] |=> state_reg.kind == mrq_pkg::KIND_FETCH_COMMAND)
      else $error("Fetch request lost priority.");
   AST_CLEAR_GRANTED: assert property (
      clk_en && state_reg.seq == ST_SETUP && !(|q_set)
      |=> !q_bits[$past(state_reg.queue)][$past(state_reg.channel)])
      else $error("Granted queue bit was not cleared.");
   AST_UPDATE_AFTER_DONE: assert property (
      clk_en && state_reg.seq == ST_MOVE && mover_link.done |=> ram_cycle == mrq_pkg::RAM_UPDATE)
      else $error("No update cycle after the last word.");
   AST_ERROR_CYCLE: assert property (
      clk_en && state_reg.seq == ST_UPDATE && state_reg.failed
      |=> ram_cycle == mrq_pkg::RAM_ERROR ##1 channel_error[$past(state_reg.channel, 2)])
      else $error("Error bit not set after failed transfer.");
   AST_HOLD_MEMORY: assert property (
      clk_en && (|queue_pending) && state_reg.seq == ST_IDLE
      && !channel_bus_word_request && !control_request_pending
      |-> hold_memory ##1 ram_cycle == mrq_pkg::RAM_SETUP)
      else $error("Memory released or next request not issued.");
   AST_GROUP_LIMIT: assert property (
      memory_request_active |-> memory_request_words <= mrq_pkg::MAX_GROUP_WORDS)
      else $error("Data group longer than four words.");
endmodule // channel_memory_request_queues

/* pkg/mrq_pkg.sv */
// Constants and types shared by the channel memory request queue design.
// Assumes one system clock; every user writes mrq_pkg::name explicitly.
package mrq_pkg;
   // ***************************************************************
   // Channel and queue geometry
   // ***************************************************************
   localparam int CHANNELS = 8;
   localparam int CHAN_W = 3;
   localparam int NUM_QUEUES = 3;
   localparam int Q_FETCH = 0;
   localparam int Q_GROUP = 1;
   localparam int Q_STORE = 2;
   // ***************************************************************
   // Word counts per request kind
   // ***************************************************************
   localparam int LEN_W = 3;
   localparam int PTR_W = 3;
   localparam logic [LEN_W-1:0] MAX_GROUP_WORDS = 3'h4;
   localparam logic [LEN_W-1:0] FETCH_WORDS = 3'h1;
   localparam logic [LEN_W-1:0] STORE_WORDS = 3'h2;
   localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
   localparam logic [CHANNELS-1:0] QUEUE_RESET = 8'h00;
   // Kinds of memory request that the block can run.
   typedef enum logic [1:0] {
      KIND_FETCH_COMMAND,
      KIND_READ_GROUP,
      KIND_WRITE_GROUP,
      KIND_STORE_COMMAND
   } request_kind_t;
   // Kinds of control RAM cycle that the block announces.
   typedef enum logic [1:0] {
      RAM_NONE,
      RAM_SETUP,
      RAM_UPDATE,
      RAM_ERROR
   } ram_cycle_t;
endpackage

/* pkg/mover_if.sv */
// Carrier between the request sequencer and the word mover.
// Assumes both ends run on the same clock and clock enable.
`timescale 1ns/1ps
interface mover_if;
   logic start;
   logic [mrq_pkg::LEN_W-1:0] total;
   logic to_controller;
   logic word_enter;
   logic word_leave;
   logic done;
   logic [mrq_pkg::LEN_W-1:0] moved;
   logic [mrq_pkg::PTR_W-1:0] offset;
   logic [mrq_pkg::LEN_W-1:0] in_buffer;
   // Sequencer side.
   modport ctrl (
      output start, total, to_controller, word_enter, word_leave,
      input done, moved, offset, in_buffer
   );
   // Counter side.
   modport mover (
      input start, total, to_controller, word_enter, word_leave,
      output done, moved, offset, in_buffer
   );
endinterface // mover_if

/* logic/request_queue.sv */
// One memory request queue: a pending bit per channel and a priority encoder.
// Assumes set and clear are steered by a single channel number each.
`timescale 1ns/1ps
module request_queue #(
   parameter int CHANNELS = 8,
   parameter int CHAN_W = 3
) (
   // Clock and control
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   // Steering of set and clear
   input wire logic set_valid,
   input wire logic [CHAN_W-1:0] set_channel,
   input wire logic clear_valid,
   input wire logic [CHAN_W-1:0] clear_channel,
   // Queue state
   output logic [CHANNELS-1:0] pending,
   output logic any_pending,
   output logic [CHAN_W-1:0] winner
);
   typedef struct packed {
      logic [CHANNELS-1:0] bits;
   } queue_state_t;
   queue_state_t state_reg;
   queue_state_t state_next;
   // Decode the steering numbers; a set in the same cycle beats a clear.
   // steered set, clear
   always_comb
   begin
      state_next = state_reg;
      for (int i = 0; i < CHANNELS; i++)
      begin
         if (clear_valid && clear_channel == CHAN_W'(i))
            state_next.bits[i] = 1'b0;
         if (set_valid && set_channel == CHAN_W'(i))
            state_next.bits[i] = 1'b1;
      end
   end
   // Register the queue; reset empties it and a low enable freezes it.
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         state_reg <= '{bits: mrq_pkg::QUEUE_RESET};
      else if (clk_en)
         state_reg <= state_next;
   end
   // Lowest numbered pending channel wins the encoder.
   // lowest channel wins
   always_comb
   begin
      winner = '0;
      for (int i = CHANNELS - 1; i >= 0; i--)
      begin
         if (state_reg.bits[i])
            winner = CHAN_W'(i);
      end
   end
   assign pending = state_reg.bits;
   assign any_pending = |state_reg.bits;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   AST_LOWEST_WINS: assert property (
      any_pending |-> pending[winner] &&
         ((pending & ((CHANNELS'(1) << winner) - CHANNELS'(1))) == '0))
      else $error("Encoder did not pick the lowest pending channel.");
   AST_SET_BEATS_CLEAR: assert property (
      clk_en && set_valid && clear_valid && set_channel == clear_channel
      |=> pending[$past(set_channel)])
      else $error("A set lost against a clear of the same channel.");
endmodule // request_queue

/* logic/word_mover.sv */
// Word counters for one memory request: words moved, buffer offset and
// words held in the memory buffers for transfers toward the controller.
// Assumes start is a one-cycle pulse issued while no transfer is running.
`timescale 1ns/1ps
module word_mover (
   // Clock and control
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   // Sequencer link
   mover_if.mover link
);
   typedef struct packed {
      logic [mrq_pkg::LEN_W-1:0] total;
      logic [mrq_pkg::LEN_W-1:0] moved;
      logic [mrq_pkg::PTR_W-1:0] offset;
      logic [mrq_pkg::LEN_W-1:0] in_buffer;
   } mover_state_t;
   mover_state_t state_reg;
   mover_state_t state_next;
   logic count_word;
   always_comb
   begin
      state_next = state_reg;
      count_word = link.to_controller ? link.word_leave : link.word_enter;
      if (link.start)
      begin
         state_next = '0;
         state_next.total = link.total;
      end
      else
      begin
         if (count_word && !link.done)
         begin
            state_next.moved = state_reg.moved + 3'h1;
            state_next.offset = state_reg.offset + 3'h1;
         end
         if (link.to_controller)
            state_next.in_buffer = state_reg.in_buffer
               + {2'h0, link.word_enter} - {2'h0, link.word_leave};
      end
   end
   // Register the counters.
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         state_reg <= '0;
      else if (clk_en)
         state_reg <= state_next;
   end
   assign link.done = (state_reg.moved == state_reg.total);
   assign link.moved = state_reg.moved;
   assign link.offset = state_reg.offset;
   assign link.in_buffer = state_reg.in_buffer;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   AST_NO_OVERCOUNT: assert property (
      state_reg.moved <= state_reg.total && state_reg.total <= mrq_pkg::MAX_GROUP_WORDS)
      else $error("Word counter passed the request length.");
endmodule // word_mover

/* tb/memory_model.sv */
// Behavioural memory buffers that answer each word of a running request.
// Assumes the bench clock and the request outputs of the queue block.
`timescale 1ns/1ps
module memory_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Request seen from the block
   input wire logic slow,
   input wire logic active,
   input wire mrq_pkg::request_kind_t kind,
   input wire logic [mrq_pkg::LEN_W-1:0] words,
   // Word strobes back to the block
   output logic word_enter,
   output logic word_leave
);
   logic [mrq_pkg::LEN_W-1:0] sent_reg;
   logic gap_reg;
   // One strobe per word, every other cycle when slow, none outside a request.
   // Every word passes the memory buffers; words toward the controller enter
   // and leave in the same cycle, so the buffers end each request empty.
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sent_reg <= 3'h0;
         gap_reg <= 1'b0;
         word_enter <= 1'b0;
         word_leave <= 1'b0;
      end
      else
      begin
         word_enter <= 1'b0;
         word_leave <= 1'b0;
         gap_reg <= slow & ~gap_reg;
         if (!active)
            sent_reg <= 3'h0;
         else if (sent_reg < words && !gap_reg)
         begin
            sent_reg <= sent_reg + 3'h1;
            word_leave <= kind == mrq_pkg::KIND_FETCH_COMMAND || kind == mrq_pkg::KIND_READ_GROUP;
            word_enter <= 1'b1;
         end
      end
   end
endmodule // memory_model

/* tb/testbench.sv */
// Self-checking bench for the channel memory request queues.
// Assumes the memory model answers words; events are one-cycle pulses.
`timescale 1ns/1ps
module testbench;
   logic clock, rst_b, clk_en, channel_start, start_controller_to_memory;
   logic word_count_zero_normal, jump_command_loaded, action_group_request, store_request;
   logic channel_bus_word_request, control_request_pending, memory_error, slow;
   logic memory_word_enter, memory_word_leave, hold_memory, memory_request_active;
   logic use_command_word_buffer;
   logic [2:0] event_channel, action_group_words, memory_request_words, ram_channel;
   logic [2:0] buffer_word_pointer, words_in_memory_buffer;
   mrq_pkg::request_kind_t memory_request_kind;
   mrq_pkg::ram_cycle_t ram_cycle;
   logic [7:0] channel_error, controller_to_memory;
   logic [23:0] queue_pending;
   int mismatches, total_checks;
   channel_memory_request_queues dut_u (.clock, .rst_b, .clk_en, .event_channel,
      .channel_start, .start_controller_to_memory, .word_count_zero_normal,
      .jump_command_loaded, .action_group_request, .action_group_words, .store_request,
      .channel_bus_word_request, .control_request_pending, .memory_word_enter,
      .memory_word_leave, .memory_error, .hold_memory, .memory_request_active,
      .memory_request_kind, .memory_request_words, .ram_cycle, .ram_channel,
      .use_command_word_buffer, .buffer_word_pointer, .words_in_memory_buffer,
      .channel_error, .controller_to_memory, .queue_pending);
   memory_model model_u (.clock, .rst_b, .slow, .active(memory_request_active),
      .kind(memory_request_kind), .words(memory_request_words),
      .word_enter(memory_word_enter), .word_leave(memory_word_leave));
   // Free-running 125 MHz clock.
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clock);
         #1;
      end
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      if (mismatches == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One event cycle: 0 start, 1 count zero, 2 jump, 3 group, 4 store, 5 none.
   task automatic pulse(input int sel, input logic [2:0] ch, input logic [2:0] len);
      event_channel = ch;
      action_group_words = len;
      channel_start = (sel == 0);
      word_count_zero_normal = (sel == 1);
      jump_command_loaded = (sel == 2);
      action_group_request = (sel == 3);
      store_request = (sel == 4);
      tick(1);
   endtask
   // Follows one grant from setup through update, optionally failing it.
   task automatic grant(input logic [2:0] ch, input logic [1:0] kind, input logic [2:0] len,
      input logic err);
      int n;
      for (n = 0; n < 60 && ram_cycle !== mrq_pkg::RAM_SETUP; n++)
         tick(1);
      check(ram_channel, ch);
      tick(1);
      check(memory_request_active, 1'b1);
      check(memory_request_kind, kind);
      check(memory_request_words, len);
      check(use_command_word_buffer, kind == 2'h0 || kind == 2'h3);
      memory_error = err;
      tick(1);
      memory_error = 1'b0;
      for (n = 0; n < 60 && ram_cycle !== mrq_pkg::RAM_UPDATE; n++)
         tick(1);
      check(ram_cycle, mrq_pkg::RAM_UPDATE);
      check(buffer_word_pointer, len);
      check(words_in_memory_buffer, 3'h0);
      tick(1);
      check(ram_cycle, err ? mrq_pkg::RAM_ERROR : mrq_pkg::RAM_NONE);
   endtask
   task automatic order_scenario;
      control_request_pending = 1'b1;
      pulse(4, 3'h2, 3'h0);
      pulse(3, 3'h5, 3'h3);
      pulse(0, 3'h3, 3'h0);
      pulse(1, 3'h1, 3'h0);
      pulse(2, 3'h6, 3'h0);
      pulse(5, 3'h0, 3'h0);
      check(queue_pending, 24'h04204a);
      check(hold_memory, 1'b1);
      control_request_pending = 1'b0;
      channel_bus_word_request = 1'b1;
      tick(3);
      check(ram_cycle, mrq_pkg::RAM_NONE);
      channel_bus_word_request = 1'b0;
      grant(3'h1, 2'h0, 3'h1, 1'b0);
      grant(3'h3, 2'h0, 3'h1, 1'b0);
      grant(3'h6, 2'h0, 3'h1, 1'b0);
      grant(3'h5, 2'h1, 3'h3, 1'b0);
      grant(3'h2, 2'h3, 3'h2, 1'b0);
      tick(2);
      check(queue_pending, 24'h000000);
   endtask
   task automatic error_scenario;
      start_controller_to_memory = 1'b1;
      control_request_pending = 1'b1;
      slow = 1'b1;
      pulse(0, 3'h4, 3'h0);
      pulse(3, 3'h4, 3'h6);
      pulse(5, 3'h4, 3'h0);
      check(controller_to_memory, 8'h10);
      control_request_pending = 1'b0;
      grant(3'h4, 2'h0, 3'h1, 1'b0);
      grant(3'h4, 2'h2, 3'h4, 1'b1);
      tick(1);
      check(channel_error, 8'h10);
   endtask
   // Main sequence: reset for 16 cycles, then the scenarios.
   initial
   begin
      {rst_b, channel_start, start_controller_to_memory, word_count_zero_normal} = 4'h0;
      {jump_command_loaded, action_group_request, store_request, memory_error} = 4'h0;
      {channel_bus_word_request, control_request_pending, slow} = 3'h0;
      clk_en = 1'b1;
      event_channel = 3'h0;
      action_group_words = 3'h0;
      mismatches = 0;
      total_checks = 0;
      repeat (16) @(posedge clock);
      #1;
      rst_b = 1'b1;
      tick(4);
      check(queue_pending, 24'h000000);
      check(hold_memory, 1'b0);
      order_scenario;
      error_scenario;
      conclude;
   end
   // Watchdog well beyond the expected run of under a hundred cycles.
   initial
   begin
      #20000;
      mismatches++;
      conclude;
   end
endmodule // testbench
